// File: src/mdpio_pkg.sv
// Package with constants and types for the meter display and pulse I/O block.
package mdpio_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LONG_PRESS_MS = 2000;
  localparam int unsigned IDLE_TIMEOUT_S = 180;
  localparam int unsigned PULSE_WIDTH_MS = 500;
  localparam int unsigned PULSE_PERIOD_MS = 1000;
  localparam int unsigned OPT_BAUD = 2400;
  localparam int unsigned BUS_BAUD_SLOW = 300;
  localparam int unsigned BUS_BAUD_FAST = 2400;
  localparam longint unsigned LONG_PRESS_CYC = longint'(CLK_HZ) * LONG_PRESS_MS / 1000;
  localparam longint unsigned IDLE_TIMEOUT_CYC = longint'(CLK_HZ) * IDLE_TIMEOUT_S;
  localparam longint unsigned PULSE_WIDTH_CYC = longint'(CLK_HZ) * PULSE_WIDTH_MS / 1000;
  localparam longint unsigned PULSE_PERIOD_CYC = longint'(CLK_HZ) * PULSE_PERIOD_MS / 1000;
  localparam longint unsigned OPT_BIT_CYC = CLK_HZ / OPT_BAUD;
  localparam longint unsigned BUS_BIT_CYC_SLOW = CLK_HZ / BUS_BAUD_SLOW;
  localparam longint unsigned BUS_BIT_CYC_FAST = CLK_HZ / BUS_BAUD_FAST;
  localparam logic [3:0] ERR_FLOW = 4'h1;
  localparam logic [3:0] ERR_TEMP = 4'h2;
  localparam logic [7:0] PRIMARY_ADDR_RST = 8'h00;
  localparam logic [15:0] PULSE_FACTOR_RST = 16'h0001;
  // Register offsets on the plain register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FACTOR_A = 4'h2;
  localparam logic [3:0] REG_FACTOR_B = 4'h3;
  localparam logic [3:0] REG_TOTAL_A = 4'h4;
  localparam logic [3:0] REG_TOTAL_B = 4'h5;
  localparam logic [3:0] REG_PADDR = 4'h6;
  localparam logic [3:0] REG_SADDR = 4'h7;
  localparam logic [3:0] REG_PEND = 4'h8;
  localparam int unsigned CTRL_COOLING_BIT = 0;
  localparam int unsigned CTRL_BUS_FAST_BIT = 1;
  typedef enum logic [2:0] {
    MDPIO_MENU_ERROR,
    MDPIO_MENU_ENERGY,
    MDPIO_MENU_MAIN,
    MDPIO_MENU_SUB,
    MDPIO_MENU_SERVICE
  } mdpio_menu_type;
endpackage : mdpio_pkg

// File: src/mdpio_top.sv
// Meter display navigation, error sum, pulse inputs and outputs, address registers.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Summed fault codes give one error value.
// - Flow over limit or defect sets code 1.
// - Temperature range or sensor fault sets 2.
// - Active fault puts error first, menus reachable.
// - Three idle minutes with fault return error.
// - Error view vanishes when faults clear.
// - Energy window is the basic display.
// - Short press advances menu or position.
// - Long press enters sub-menu or returns.
// - Three idle minutes revert to energy window.
// - Two pulse inputs count into separate totals.
// - Programmable pulse factor, default one.
// - Output b is volume or cooling energy.
// - One output pulse per digit increment; increments beyond 255 pending are dropped.
// - Open collector, 500 ms pulse, 1 Hz max.
// - Optical port fixed at 2400 baud.
// - Primary address zero, secondary is serial.
// - Secondary address writable via bus/software.
// - Bus supports 300 and 2400 baud.
// - Service menu shows primary address.
module mdpio_top #(
  parameter longint unsigned LONG_PRESS_CYC = mdpio_pkg::LONG_PRESS_CYC,
  parameter longint unsigned IDLE_TIMEOUT_CYC = mdpio_pkg::IDLE_TIMEOUT_CYC,
  parameter longint unsigned PULSE_WIDTH_CYC = mdpio_pkg::PULSE_WIDTH_CYC,
  parameter longint unsigned PULSE_PERIOD_CYC = mdpio_pkg::PULSE_PERIOD_CYC,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  parameter int unsigned TOTAL_W = 32,
  parameter int unsigned PEND_W = 8,
  parameter int unsigned SUB_POS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic button_n,
  input wire logic flow_over_limit,
  input wire logic flow_sensor_fault,
  input wire logic temp_out_of_range,
  input wire logic temp_sensor_fault,
  input wire logic pulse_in_a,
  input wire logic pulse_in_b,
  input wire logic energy_heat_inc,
  input wire logic energy_cool_inc,
  input wire logic volume_inc,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [3:0] error_code,
  output logic [2:0] menu_state,
  output logic [2:0] menu_pos,
  output logic pulse_output_a_o,
  output logic pulse_output_a_oe,
  output logic pulse_output_b_o,
  output logic pulse_output_b_oe,
  output logic [31:0] opt_bit_cycles,
  output logic [31:0] bus_bit_cycles
);
  localparam int unsigned CW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [6:0] pin_raw;
  assign pin_raw = {temp_sensor_fault, temp_out_of_range, flow_sensor_fault, flow_over_limit,
                    pulse_in_b, pulse_in_a, ~button_n};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  logic btn;
  assign btn = pin_s2_q[0];
  logic [1:0] pin_in_prev_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_in_prev_q <= 2'h0;
    end else begin
      pin_in_prev_q <= pin_s2_q[2:1];
    end
  end
  logic [1:0] in_edge;
  assign in_edge = pin_s2_q[2:1] & ~pin_in_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault codes.
  logic [3:0] err_d;
  assign err_d = ((pin_s2_q[3] | pin_s2_q[4]) ? mdpio_pkg::ERR_FLOW : 4'h0)
               + ((pin_s2_q[5] | pin_s2_q[6]) ? mdpio_pkg::ERR_TEMP : 4'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_code <= 4'h0;
    end else begin
      error_code <= err_d;
    end
  end
  logic fault;
  assign fault = err_d != 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Button press classification.
  logic [CW-1:0] hold_q;
  logic long_done_q;
  logic short_evt;
  logic long_evt;
  assign long_evt = btn && !long_done_q && hold_q == CW'(LONG_PRESS_CYC - 1);
  assign short_evt = !btn && hold_q != '0 && !long_done_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
      long_done_q <= 1'b0;
    end else if (btn) begin
      if (hold_q != CW'(LONG_PRESS_CYC)) begin
        hold_q <= hold_q + CW'(1);
      end
      if (long_evt) begin
        long_done_q <= 1'b1;
      end
    end else begin
      hold_q <= '0;
      long_done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Menu navigation.
  logic [CW-1:0] idle_q;
  logic idle_evt;
  assign idle_evt = idle_q == CW'(IDLE_TIMEOUT_CYC - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
    end else if (btn || idle_evt) begin
      idle_q <= '0;
    end else begin
      idle_q <= idle_q + CW'(1);
    end
  end
  mdpio_pkg::mdpio_menu_type menu_q;
  logic [2:0] pos_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      menu_q <= mdpio_pkg::MDPIO_MENU_ENERGY;
      pos_q <= 3'h0;
    end else if (idle_evt) begin
      menu_q <= fault ? mdpio_pkg::MDPIO_MENU_ERROR : mdpio_pkg::MDPIO_MENU_ENERGY;
      pos_q <= 3'h0;
    end else if (!fault && menu_q == mdpio_pkg::MDPIO_MENU_ERROR) begin
      menu_q <= mdpio_pkg::MDPIO_MENU_ENERGY;
      pos_q <= 3'h0;
    end else if (long_evt) begin
      pos_q <= 3'h0;
      unique case (menu_q)
        mdpio_pkg::MDPIO_MENU_ENERGY: menu_q <= mdpio_pkg::MDPIO_MENU_SUB;
        default: menu_q <= mdpio_pkg::MDPIO_MENU_ENERGY;
      endcase
    end else if (short_evt) begin
      unique case (menu_q)
        mdpio_pkg::MDPIO_MENU_ERROR: menu_q <= mdpio_pkg::MDPIO_MENU_ENERGY;
        mdpio_pkg::MDPIO_MENU_ENERGY: menu_q <= mdpio_pkg::MDPIO_MENU_MAIN;
        mdpio_pkg::MDPIO_MENU_MAIN: menu_q <= mdpio_pkg::MDPIO_MENU_SERVICE;
        mdpio_pkg::MDPIO_MENU_SERVICE: menu_q <= fault ? mdpio_pkg::MDPIO_MENU_ERROR
                                                       : mdpio_pkg::MDPIO_MENU_ENERGY;
        mdpio_pkg::MDPIO_MENU_SUB: pos_q <= (pos_q == 3'(SUB_POS - 1)) ? 3'h0 : pos_q + 3'h1;
        default: menu_q <= mdpio_pkg::MDPIO_MENU_ENERGY;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      menu_state <= 3'(mdpio_pkg::MDPIO_MENU_ENERGY);
      menu_pos <= 3'h0;
    end else begin
      menu_state <= 3'(menu_q);
      menu_pos <= pos_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [1:0] ctrl_q;
  logic [15:0] factor_q [2];
  logic [TOTAL_W-1:0] total_q [2];
  logic [15:0] pcount_q [2];
  logic [7:0] paddr_q;
  logic [31:0] saddr_q;
  logic saddr_init_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 2'h0;
      factor_q[0] <= mdpio_pkg::PULSE_FACTOR_RST;
      factor_q[1] <= mdpio_pkg::PULSE_FACTOR_RST;
      paddr_q <= mdpio_pkg::PRIMARY_ADDR_RST;
      saddr_q <= 32'h0;
      saddr_init_q <= 1'b0;
    end else begin
      if (!saddr_init_q) begin
        saddr_q <= SERIAL_NUMBER;
        saddr_init_q <= 1'b1;
      end
      if (reg_wr) begin
        unique case (reg_addr)
          mdpio_pkg::REG_CTRL: ctrl_q <= reg_wdata[1:0];
          mdpio_pkg::REG_FACTOR_A: factor_q[0] <= (reg_wdata[15:0] == 16'h0) ? mdpio_pkg::PULSE_FACTOR_RST
                                                                             : reg_wdata[15:0];
          mdpio_pkg::REG_FACTOR_B: factor_q[1] <= (reg_wdata[15:0] == 16'h0) ? mdpio_pkg::PULSE_FACTOR_RST
                                                                             : reg_wdata[15:0];
          mdpio_pkg::REG_PADDR: paddr_q <= reg_wdata[7:0];
          mdpio_pkg::REG_SADDR: saddr_q <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Pulse totalizers: a unit counts after factor pulses.
  for (genvar i = 0; i < 2; i++) begin : g_in
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pcount_q[i] <= 16'h0;
        total_q[i] <= '0;
      end else if (in_edge[i]) begin
        if (pcount_q[i] + 16'h1 >= factor_q[i]) begin
          pcount_q[i] <= 16'h0;
          total_q[i] <= total_q[i] + TOTAL_W'(1);
        end else begin
          pcount_q[i] <= pcount_q[i] + 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse outputs with pending queues.
  logic [1:0] inc;
  assign inc = {ctrl_q[mdpio_pkg::CTRL_COOLING_BIT] ? energy_cool_inc : volume_inc, energy_heat_inc};
  logic [PEND_W-1:0] pend_q [2];
  logic [CW-1:0] ptim_q [2];
  logic drive_q [2];
  for (genvar i = 0; i < 2; i++) begin : g_out
    logic start;
    assign start = ptim_q[i] == '0 && pend_q[i] != '0;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pend_q[i] <= '0;
      end else if (inc[i] && !start) begin
        if (pend_q[i] != '1) begin
          pend_q[i] <= pend_q[i] + PEND_W'(1);
        end
      end else if (!inc[i] && start) begin
        pend_q[i] <= pend_q[i] - PEND_W'(1);
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ptim_q[i] <= '0;
        drive_q[i] <= 1'b0;
      end else if (start) begin
        ptim_q[i] <= CW'(PULSE_PERIOD_CYC - 1);
        drive_q[i] <= 1'b1;
      end else if (ptim_q[i] != '0) begin
        ptim_q[i] <= ptim_q[i] - CW'(1);
        drive_q[i] <= ptim_q[i] > CW'(PULSE_PERIOD_CYC - PULSE_WIDTH_CYC);
      end else begin
        drive_q[i] <= 1'b0;
      end
    end
  end
  // Open collector: output low, enabled only while the pulse is active.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_output_a_o <= 1'b0;
      pulse_output_b_o <= 1'b0;
      pulse_output_a_oe <= 1'b0;
      pulse_output_b_oe <= 1'b0;
    end else begin
      pulse_output_a_o <= 1'b0;
      pulse_output_b_o <= 1'b0;
      pulse_output_a_oe <= drive_q[0];
      pulse_output_b_oe <= drive_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud settings and read port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_bit_cycles <= 32'(mdpio_pkg::OPT_BIT_CYC);
      bus_bit_cycles <= 32'(mdpio_pkg::BUS_BIT_CYC_SLOW);
    end else begin
      opt_bit_cycles <= 32'(mdpio_pkg::OPT_BIT_CYC);
      bus_bit_cycles <= ctrl_q[mdpio_pkg::CTRL_BUS_FAST_BIT] ? 32'(mdpio_pkg::BUS_BIT_CYC_FAST)
                                                             : 32'(mdpio_pkg::BUS_BIT_CYC_SLOW);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        mdpio_pkg::REG_CTRL: reg_rdata <= {30'h0, ctrl_q};
        mdpio_pkg::REG_STATUS: reg_rdata <= {22'h0, pos_q, 3'(menu_q), error_code};
        mdpio_pkg::REG_FACTOR_A: reg_rdata <= {16'h0, factor_q[0]};
        mdpio_pkg::REG_FACTOR_B: reg_rdata <= {16'h0, factor_q[1]};
        mdpio_pkg::REG_TOTAL_A: reg_rdata <= 32'(total_q[0]);
        mdpio_pkg::REG_TOTAL_B: reg_rdata <= 32'(total_q[1]);
        mdpio_pkg::REG_PADDR: reg_rdata <= {24'h0, paddr_q};
        mdpio_pkg::REG_SADDR: reg_rdata <= saddr_q;
        mdpio_pkg::REG_PEND: reg_rdata <= {16'h0, 8'(pend_q[1]), 8'(pend_q[0])};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_err_sum: assert property (@(posedge clk) disable iff (!rst_n)
    error_code == ((($past(pin_s2_q[3]) | $past(pin_s2_q[4])) ? 4'h1 : 4'h0)
                 + (($past(pin_s2_q[5]) | $past(pin_s2_q[6])) ? 4'h2 : 4'h0)))
    else $error("error code is not the sum of fault codes");
  a_flow_code: assert property (@(posedge clk) disable iff (!rst_n)
    pin_s2_q[3] |=> error_code[0]) else $error("flow fault not reported");
  a_temp_code: assert property (@(posedge clk) disable iff (!rst_n)
    pin_s2_q[6] |=> error_code[1]) else $error("temperature fault not reported");
  a_idle_error: assert property (@(posedge clk) disable iff (!rst_n)
    idle_evt && fault |=> menu_q == mdpio_pkg::MDPIO_MENU_ERROR) else $error("idle did not show error");
  a_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !fault && menu_q == mdpio_pkg::MDPIO_MENU_ERROR |=> menu_q == mdpio_pkg::MDPIO_MENU_ENERGY)
    else $error("error view not removed");
  a_idle_energy: assert property (@(posedge clk) disable iff (!rst_n)
    idle_evt && !fault |=> menu_q == mdpio_pkg::MDPIO_MENU_ENERGY) else $error("idle did not revert");
  a_short_adv: assert property (@(posedge clk) disable iff (!rst_n)
    short_evt && !idle_evt && menu_q == mdpio_pkg::MDPIO_MENU_ENERGY && fault == $past(fault)
    |=> menu_q == mdpio_pkg::MDPIO_MENU_MAIN) else $error("short press did not advance");
  a_long_entry: assert property (@(posedge clk) disable iff (!rst_n)
    long_evt && !idle_evt && menu_q == mdpio_pkg::MDPIO_MENU_ENERGY |=> menu_q == mdpio_pkg::MDPIO_MENU_SUB)
    else $error("long press did not enter sub-menu");
  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_n)
    ptim_q[0] == '0 && pend_q[0] != '0 |=> ##1 drive_q[0]) else $error("pending pulse not emitted");
  a_pulse_gap: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(drive_q[0]) |=> ptim_q[0] != '0) else $error("pulse period violated");
  a_queue_keep: assert property (@(posedge clk) disable iff (!rst_n)
    inc[0] && ptim_q[0] != '0 && pend_q[0] != '1 |=> pend_q[0] == $past(pend_q[0]) + PEND_W'(1))
    else $error("increment lost from pulse queue");
  a_cool_route: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_q[mdpio_pkg::CTRL_COOLING_BIT] && energy_cool_inc && pend_q[1] == '0 && ptim_q[1] == '0
    |=> pend_q[1] != '0) else $error("cooling increment not routed to output b");

  // Length of the current low pulse on output a; a counter avoids a long repetition in the property.
  logic [CW-1:0] oe_run_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_run_q <= '0;
    end else if (pulse_output_a_oe) begin
      oe_run_q <= oe_run_q + CW'(1);
    end else begin
      oe_run_q <= '0;
    end
  end
  a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pulse_output_a_oe) |-> oe_run_q == CW'(PULSE_WIDTH_CYC)) else $error("output pulse width wrong");
  c_cool_pulse: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_q[mdpio_pkg::CTRL_COOLING_BIT] && pulse_output_b_oe);
  c_long_press: cover property (@(posedge clk) disable iff (!rst_n) long_evt);
  c_both_faults: cover property (@(posedge clk) disable iff (!rst_n) error_code == 4'h3);
  c_queued: cover property (@(posedge clk) disable iff (!rst_n) pend_q[0] > PEND_W'(1));
endmodule : mdpio_top

// File: tb/mdpio_far_side.sv
// Far side model: two external pulse meters and the pulled-up open-collector output lines.
`timescale 1ns/1ps
module mdpio_far_side (
  input wire logic clk,
  input wire logic out_a_o,
  input wire logic out_a_oe,
  input wire logic out_b_o,
  input wire logic out_b_oe,
  output logic pulse_in_a,
  output logic pulse_in_b,
  output logic [15:0] count_a,
  output logic [15:0] count_b,
  output logic [15:0] width_a
);
  logic line_a;
  logic line_b;
  logic line_b_q;
  logic [15:0] run_a;
  // The outputs only sink current, so a released line is lifted by the pull-up.
  assign line_a = out_a_oe ? out_a_o : 1'b1;
  assign line_b = out_b_oe ? out_b_o : 1'b1;
  initial begin
    pulse_in_a = 1'b0;
    pulse_in_b = 1'b0;
    count_a = 16'h0000;
    count_b = 16'h0000;
    width_a = 16'h0000;
    run_a = 16'h0000;
    line_b_q = 1'b1;
  end
  // Pulses are counted on the wire level, and the low time of line a is measured in cycles.
  always @(posedge clk) begin
    line_b_q <= line_b;
    if (!line_a) begin
      run_a <= run_a + 16'h0001;
    end else if (run_a != 16'h0000) begin
      width_a <= run_a;
      count_a <= count_a + 16'h0001;
      run_a <= 16'h0000;
    end
    if (line_b_q && !line_b) begin
      count_b <= count_b + 16'h0001;
    end
  end
  // A meter pulse is held high long enough to pass the input synchroniser.
  task automatic send_pulses(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (sel) pulse_in_b <= 1'b1;
      else pulse_in_a <= 1'b1;
      repeat (3) @(posedge clk);
      pulse_in_a <= 1'b0;
      pulse_in_b <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : send_pulses
endmodule : mdpio_far_side

// File: tb/meter_display_pulse_io_bench.sv
// Self-checking testbench for the meter display and pulse I/O block.
`timescale 1ns/1ps
module meter_display_pulse_io_bench;
  localparam logic [31:0] SERIAL = 32'h1234_5678; // Arbitrary serial number.
  logic clk, rst_n, button_n, flow_over_limit, flow_sensor_fault, temp_out_of_range, temp_sensor_fault;
  logic pulse_in_a, pulse_in_b, energy_heat_inc, energy_cool_inc, volume_inc, reg_wr, reg_rd;
  logic [3:0] reg_addr, error_code;
  logic [31:0] reg_wdata, reg_rdata, opt_bit_cycles, bus_bit_cycles;
  logic [2:0] menu_state, menu_pos;
  logic out_a_o, out_a_oe, out_b_o, out_b_oe;
  logic [15:0] count_a, count_b, width_a;
  int failures = 0;
  int check_count = 0;
  mdpio_top #(.LONG_PRESS_CYC(20), .IDLE_TIMEOUT_CYC(200), .PULSE_WIDTH_CYC(5), .PULSE_PERIOD_CYC(10),
    .SERIAL_NUMBER(SERIAL)) DUT (.clk(clk), .rst_n(rst_n), .button_n(button_n),
    .flow_over_limit(flow_over_limit), .flow_sensor_fault(flow_sensor_fault),
    .temp_out_of_range(temp_out_of_range), .temp_sensor_fault(temp_sensor_fault),
    .pulse_in_a(pulse_in_a), .pulse_in_b(pulse_in_b), .energy_heat_inc(energy_heat_inc),
    .energy_cool_inc(energy_cool_inc), .volume_inc(volume_inc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .error_code(error_code), .menu_state(menu_state),
    .menu_pos(menu_pos), .pulse_output_a_o(out_a_o), .pulse_output_a_oe(out_a_oe), .pulse_output_b_o(out_b_o),
    .pulse_output_b_oe(out_b_oe), .opt_bit_cycles(opt_bit_cycles), .bus_bit_cycles(bus_bit_cycles));
  mdpio_far_side FAR (.clk(clk), .out_a_o(out_a_o), .out_a_oe(out_a_oe), .out_b_o(out_b_o), .out_b_oe(out_b_oe),
    .pulse_in_a(pulse_in_a), .pulse_in_b(pulse_in_b), .count_a(count_a), .count_b(count_b), .width_a(width_a));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : reg_read
  task automatic set_faults(input logic [3:0] f, input logic [3:0] exp);
    @(posedge clk);
    {flow_over_limit, flow_sensor_fault, temp_out_of_range, temp_sensor_fault} <= f;
    repeat (6) @(posedge clk);
    #1;
    check({28'h0, error_code}, {28'h0, exp});
  endtask : set_faults
  task automatic press(input int n, input logic [2:0] exp);
    @(posedge clk);
    button_n <= 1'b0;
    repeat (n) @(posedge clk);
    button_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check({29'h0, menu_state}, {29'h0, exp});
  endtask : press
  task automatic emit_inc(input logic [2:0] sel, input int n);
    @(posedge clk);
    {energy_heat_inc, energy_cool_inc, volume_inc} <= sel;
    repeat (n) @(posedge clk);
    {energy_heat_inc, energy_cool_inc, volume_inc} <= 3'h0;
    repeat (40) @(posedge clk);
    #1;
  endtask : emit_inc
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, energy_heat_inc, energy_cool_inc, volume_inc} = 6'h00;
    {flow_over_limit, flow_sensor_fault, temp_out_of_range, temp_sensor_fault} = 4'h0;
    button_n = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({29'h0, menu_state}, 32'h1);
    check(opt_bit_cycles, 32'd4166);
    check(bus_bit_cycles, 32'd33333);
    reg_read(mdpio_pkg::REG_PADDR, 32'h0);
    reg_read(mdpio_pkg::REG_SADDR, SERIAL);
    reg_read(mdpio_pkg::REG_FACTOR_A, 32'h1);
    reg_read(4'hf, 32'h0);
    $display("test reset values done");
    set_faults(4'h8, 4'h1);
    set_faults(4'h4, 4'h1);
    set_faults(4'h2, 4'h2);
    set_faults(4'h1, 4'h2);
    set_faults(4'ha, 4'h3);
    set_faults(4'h5, 4'h3);
    set_faults(4'h8, 4'h1);
    $display("test error codes done");
    press(15, 3'h2);
    press(3, 3'h4);
    press(3, 3'h0);
    press(3, 3'h1);
    press(30, 3'h3);
    press(3, 3'h3);
    check({29'h0, menu_pos}, 32'h1);
    press(30, 3'h1);
    press(3, 3'h2);
    repeat (210) @(posedge clk);
    #1;
    check({29'h0, menu_state}, 32'h0);
    set_faults(4'h0, 4'h0);
    check({29'h0, menu_state}, 32'h1);
    press(3, 3'h2);
    repeat (210) @(posedge clk);
    #1;
    check({29'h0, menu_state}, 32'h1);
    $display("test menu navigation done");
    reg_write(mdpio_pkg::REG_FACTOR_A, 32'h3);
    FAR.send_pulses(1'b0, 6);
    FAR.send_pulses(1'b1, 4);
    repeat (5) @(posedge clk);
    reg_read(mdpio_pkg::REG_TOTAL_A, 32'h2);
    reg_read(mdpio_pkg::REG_TOTAL_B, 32'h4);
    reg_write(mdpio_pkg::REG_FACTOR_B, 32'h0);
    reg_read(mdpio_pkg::REG_FACTOR_B, 32'h1);
    $display("test pulse inputs done");
    emit_inc(3'h4, 3);
    check({16'h0, count_a}, 32'h3);
    check({16'h0, width_a}, 32'h5);
    check({31'h0, out_a_o}, 32'h0);
    check({31'h0, out_b_o}, 32'h0);
    reg_write(mdpio_pkg::REG_CTRL, 32'h1);
    emit_inc(3'h1, 1);
    emit_inc(3'h2, 1);
    check({16'h0, count_b}, 32'h1);
    reg_write(mdpio_pkg::REG_CTRL, 32'h2);
    emit_inc(3'h2, 1);
    emit_inc(3'h1, 2);
    check({16'h0, count_b}, 32'h3);
    check({16'h0, count_a}, 32'h3);
    check(bus_bit_cycles, 32'd4166);
    check(opt_bit_cycles, 32'd4166);
    reg_read(mdpio_pkg::REG_CTRL, 32'h2);
    reg_read(mdpio_pkg::REG_PEND, 32'h0);
    $display("test pulse outputs done");
    reg_write(mdpio_pkg::REG_SADDR, 32'h0000_abcd);
    reg_read(mdpio_pkg::REG_SADDR, 32'h0000_abcd);
    reg_write(mdpio_pkg::REG_PADDR, 32'h0000_0005);
    reg_read(mdpio_pkg::REG_PADDR, 32'h0000_0005);
    reg_read(mdpio_pkg::REG_STATUS, 32'h0000_0010);
    $display("test addresses done");
    give_verdict();
  end
endmodule : meter_display_pulse_io_bench
